// *** design/rvc_core.sv ***
// Serial-bus target, setpoint registers, setpoint ramp and power-good logic of a step-down regulator.
// Assumes SCL, SDA, select pin and window comparator are asynchronous; SDA is open drain.
//
// Notes on behaviour
// - Fixed target address and preset start-up setpoint, no resistor selection.
// - After start-up the select pin picks which setpoint register is used.
// - Select low uses the first setting, high uses the second.
// - During a setpoint change force PWM when the control bit asks.
// - Setpoint steps toward target at the programmed ramp speed.
// - Power-good released inside the window, pulled low outside it.
// - Power-good changes only after a deglitch delay in normal operation.
// - Serial target works at 100k, 400k, 1M and 3.4M bit rates.
// - Start is SDA falling while SCL is high.
// - SDA stays stable while SCL is high except start and stop.
// - Acknowledge only a matching address, low through the ninth clock high.
// - Direction zero writes, direction one reads.
// - The receiving party acknowledges each byte.
// - Byte plus acknowledge groups repeat until stop or repeated start.
// - Stop is SDA rising while SCL high; then wait for new start.
// - Reading an unimplemented register returns zero.
// - High-speed code is not acknowledged but enables high-speed mode.
// - High-speed mode stays through repeated starts, ends on stop.
// - A write is address, register index and data, each acknowledged.
// - Written data commits on the falling edge of its acknowledge.
// - Index byte has upper five bits zero, lower three select register.
// - Setpoint registers at indices one and two, reset to 0x64.
// - Ramp field 00..11 gives 20, 10, 5, 1 mV per microsecond.
`timescale 1ns/1ps
`default_nettype none
module rvc_core
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic setpoint_select_pin,
   input wire logic startup_done,
   input wire logic vout_in_window,
   input wire logic thermal_warning,
   input wire logic hiccup_seen,
   output logic power_good_output,
   output logic power_good_oe,
   output logic [7:0] setpoint_code,
   output logic forced_pwm_operation,
   output logic light_load_pwm,
   output logic sw_enable,
   output logic discharge_enable,
   output logic hiccup_enable,
   output logic [1:0] ramp_speed,
   output logic hs_mode
);
   // ****************************************************
   // Input synchronisation and bus events
   // ****************************************************
   logic scl_s, sda_s, sel_s, win_s;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_evt, stop_evt;

   rvc_sync #(.WIDTH(4)) u_sync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in({scl_in, sda_in, setpoint_select_pin, vout_in_window}),
      .sync_out({scl_s, sda_s, sel_s, win_s})
   );

   // Edge and condition detection on the filtered lines
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_evt = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_evt = scl_s & scl_q & ~sda_q & sda_s;

   // ****************************************************
   // Register file access
   // ****************************************************
   logic [7:0] v1_q, v1_d, v2_q, v2_d, ctrl_q, ctrl_d;

   // Index byte is valid only with its upper bits clear
   function automatic logic idx_ok(input logic [7:0] idx);
      idx_ok = (idx[7:3] == 5'h00);
   endfunction

   // Read value of an index; anything unlisted reads zero
   function automatic logic [7:0] rd_val(input logic [7:0] idx);
      rd_val = 8'h00;
      if (idx_ok(idx))
      begin
         unique case (idx[2:0])
            rvc_pkg::IDX_V1: rd_val = v1_q;
            rvc_pkg::IDX_V2: rd_val = v2_q;
            rvc_pkg::IDX_CTRL: rd_val = ctrl_q;
            rvc_pkg::IDX_STAT:
            begin
               rd_val[rvc_pkg::STAT_THERM] = thermal_warning;
               rd_val[rvc_pkg::STAT_HICCUP] = hiccup_seen;
            end
            default: rd_val = 8'h00;
         endcase
      end
   endfunction

   // ****************************************************
   // Serial target engine
   // ****************************************************
   rvc_pkg::rvc_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, idx_q, idx_d;
   logic rw_q, rw_d, oe_q, oe_d, hs_q, hs_d, mack_q, mack_d;

   // Next state of the target, including register commits
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      idx_d = idx_q;
      rw_d = rw_q;
      oe_d = oe_q;
      hs_d = hs_q;
      mack_d = mack_q;
      v1_d = v1_q;
      v2_d = v2_q;
      ctrl_d = ctrl_q;
      if (stop_evt)
      begin
         st_d = rvc_pkg::ST_IDLE;
         oe_d = 1'b0;
         hs_d = 1'b0;
      end
      else if (start_evt)
      begin
         st_d = rvc_pkg::ST_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end
      else if (scl_rise)
      begin
         // Sample on SCL high; data is stable there
         if (st_q inside {rvc_pkg::ST_ADDR, rvc_pkg::ST_REG, rvc_pkg::ST_WR})
         begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
         end
         else if (st_q == rvc_pkg::ST_RD)
         begin
            cnt_d = cnt_q + 4'h1;
         end
         else if (st_q == rvc_pkg::ST_ACK_RD)
         begin
            mack_d = ~sda_s;
         end
      end
      else if (scl_fall)
      begin
         unique case (st_q)
            rvc_pkg::ST_IDLE:
            begin
            end
            rvc_pkg::ST_ADDR:
            begin
               if (cnt_q == rvc_pkg::BITS_PER_BYTE)
               begin
                  cnt_d = 4'h0;
                  if (sh_q[7:1] == rvc_pkg::OWN_ADDR)
                  begin
                     oe_d = 1'b1;
                     rw_d = sh_q[0];
                     st_d = rvc_pkg::ST_ACK_ADDR;
                  end
                  else
                  begin
                     if (sh_q[7:3] == rvc_pkg::HS_CODE)
                     begin
                        hs_d = 1'b1;
                     end
                     st_d = rvc_pkg::ST_IDLE;
                  end
               end
            end
            rvc_pkg::ST_REG, rvc_pkg::ST_WR:
            begin
               if (cnt_q == rvc_pkg::BITS_PER_BYTE)
               begin
                  cnt_d = 4'h0;
                  oe_d = 1'b1;
                  if (st_q == rvc_pkg::ST_REG)
                  begin
                     idx_d = sh_q;
                     st_d = rvc_pkg::ST_ACK_REG;
                  end
                  else
                  begin
                     st_d = rvc_pkg::ST_ACK_WR;
                  end
               end
            end
            rvc_pkg::ST_ACK_ADDR, rvc_pkg::ST_ACK_RD:
            begin
               if ((st_q == rvc_pkg::ST_ACK_ADDR && rw_q) || (st_q == rvc_pkg::ST_ACK_RD && mack_q))
               begin
                  sh_d = rd_val(idx_q);
                  oe_d = ~sh_d[7];
                  cnt_d = 4'h0;
                  st_d = rvc_pkg::ST_RD;
               end
               else
               begin
                  oe_d = 1'b0;
                  st_d = (st_q == rvc_pkg::ST_ACK_ADDR) ? rvc_pkg::ST_REG : rvc_pkg::ST_IDLE;
               end
            end
            rvc_pkg::ST_ACK_REG:
            begin
               oe_d = 1'b0;
               st_d = rvc_pkg::ST_WR;
            end
            rvc_pkg::ST_ACK_WR:
            begin
               oe_d = 1'b0;
               st_d = rvc_pkg::ST_WR;
               if (idx_ok(idx_q))
               begin
                  unique case (idx_q[2:0])
                     rvc_pkg::IDX_V1: v1_d = sh_q;
                     rvc_pkg::IDX_V2: v2_d = sh_q;
                     rvc_pkg::IDX_CTRL: ctrl_d = sh_q;
                     default: ctrl_d = ctrl_q;
                  endcase
               end
            end
            rvc_pkg::ST_RD:
            begin
               if (cnt_q == rvc_pkg::BITS_PER_BYTE)
               begin
                  oe_d = 1'b0; // Controller acknowledges
                  mack_d = 1'b0;
                  st_d = rvc_pkg::ST_ACK_RD;
               end
               else
               begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            end
         endcase
      end
      // Software reset bit restores every register, itself included
      if (ctrl_q[rvc_pkg::CTRL_RESET])
      begin
         v1_d = rvc_pkg::V_RST;
         v2_d = rvc_pkg::V_RST;
         ctrl_d = rvc_pkg::CTRL_RST;
      end
   end

   // Engine and register state
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         st_q <= rvc_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         idx_q <= 8'h00;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
         hs_q <= 1'b0;
         mack_q <= 1'b0;
         v1_q <= rvc_pkg::V_RST;
         v2_q <= rvc_pkg::V_RST;
         ctrl_q <= rvc_pkg::CTRL_RST;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         idx_q <= idx_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         hs_q <= hs_d;
         mack_q <= mack_d;
         v1_q <= v1_d;
         v2_q <= v2_d;
         ctrl_q <= ctrl_d;
      end
   end

   // ****************************************************
   // Setpoint selection and ramp
   // ****************************************************
   logic [7:0] target, code_q, code_d;
   logic [8:0] tmr_q, tmr_d, step_per;
   logic ramping;

   // Select pin takes effect only once start-up is over
   assign target = (startup_done && sel_s) ? v2_q : v1_q;
   assign ramping = (code_q != target);

   // Step one code per ramp period toward the target
   always_comb
   begin
      unique case (ctrl_q[1:0])
         2'h0: step_per = rvc_pkg::STEP0_CYC;
         2'h1: step_per = rvc_pkg::STEP1_CYC;
         2'h2: step_per = rvc_pkg::STEP2_CYC;
         2'h3: step_per = rvc_pkg::STEP3_CYC;
      endcase
      code_d = code_q;
      tmr_d = tmr_q + 9'h001;
      if (!ramping)
      begin
         tmr_d = 9'h000;
      end
      else if (tmr_q >= step_per - 9'h001)
      begin
         tmr_d = 9'h000;
         code_d = (code_q < target) ? code_q + 8'h01 : code_q - 8'h01;
      end
   end

   // ****************************************************
   // Power-good deglitch
   // ****************************************************
   logic pg_q, pg_d;
   logic [9:0] dg_q, dg_d;

   // Window result must hold for the deglitch time before it shows
   always_comb
   begin
      pg_d = pg_q;
      dg_d = 10'h000;
      if (!ctrl_q[rvc_pkg::CTRL_SWEN])
      begin
         pg_d = 1'b0;
      end
      else if (win_s != pg_q)
      begin
         if (dg_q == rvc_pkg::PG_DEGLITCH_CYC - 10'h001)
         begin
            pg_d = win_s;
         end
         else
         begin
            dg_d = dg_q + 10'h001;
         end
      end
   end

   // Ramp and power-good state
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         code_q <= rvc_pkg::V_RST;
         tmr_q <= 9'h000;
         pg_q <= 1'b0;
         dg_q <= 10'h000;
      end
      else
      begin
         code_q <= code_d;
         tmr_q <= tmr_d;
         pg_q <= pg_d;
         dg_q <= dg_d;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign sda_out = 1'b0;
   assign sda_oe = oe_q;
   assign power_good_output = 1'b0;
   assign power_good_oe = ~pg_q;
   assign setpoint_code = code_q;
   assign forced_pwm_operation = ctrl_q[rvc_pkg::CTRL_FORCED_PWM_OPERATION] | (ramping & ctrl_q[rvc_pkg::CTRL_FORCED_PWM_OPERATION_CHG]);
   assign light_load_pwm = ctrl_q[rvc_pkg::CTRL_FORCED_PWM_OPERATION];
   assign sw_enable = ctrl_q[rvc_pkg::CTRL_SWEN];
   assign discharge_enable = ctrl_q[rvc_pkg::CTRL_DISCH];
   assign hiccup_enable = ctrl_q[rvc_pkg::CTRL_HICCUP];
   assign ramp_speed = ctrl_q[1:0];
   assign hs_mode = hs_q;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_ack_addr_match: assert property ($rose(st_q == rvc_pkg::ST_ACK_ADDR) |-> oe_q && $past(sh_q[7:1]) == rvc_pkg::OWN_ADDR) else $error("address ack without match");
   a_hs_no_ack: assert property ($rose(hs_q) |-> !oe_q && st_q == rvc_pkg::ST_IDLE) else $error("high-speed code acknowledged");
   a_stop_ends_hs: assert property (stop_evt |=> !hs_q && !oe_q) else $error("stop did not end high-speed mode");
   a_select_choice: assert property (startup_done && sel_s |-> target == v2_q) else $error("select pin ignored");
   a_forced_pwm_operation_force: assert property (ramping && ctrl_q[rvc_pkg::CTRL_FORCED_PWM_OPERATION_CHG] |-> forced_pwm_operation) else $error("no forced PWM while ramping");
   a_pg_deglitch: assert property ($changed(pg_q) && $past(ctrl_q[rvc_pkg::CTRL_SWEN]) |-> $past(dg_q) == rvc_pkg::PG_DEGLITCH_CYC - 10'h001) else $error("power-good changed early");
   a_commit_v1: assert property (st_q == rvc_pkg::ST_ACK_WR && scl_fall && idx_q == 8'h01 && !stop_evt && !start_evt && !ctrl_q[rvc_pkg::CTRL_RESET] |=> v1_q == $past(sh_q)) else $error("write not committed");
   a_unmapped_zero: assert property ($rose(st_q == rvc_pkg::ST_RD) && !idx_ok(idx_q) |-> sh_q == 8'h00 && oe_q) else $error("unmapped read not zero");
   a_ramp_step: assert property ($changed(code_q) |-> code_q == $past(code_q) + 8'h01 || code_q == $past(code_q) - 8'h01) else $error("setpoint jumped");

   c_write: cover property (st_q == rvc_pkg::ST_ACK_WR && scl_fall);
   c_read: cover property (st_q == rvc_pkg::ST_ACK_RD && scl_fall && mack_q);
   c_hs: cover property ($rose(hs_q));
   c_pg: cover property ($rose(pg_q));
endmodule
`default_nettype wire

// *** design/rvc_pkg.sv ***
// Shared constants and types of the regulator serial-control block.
// Assumes a 50 MHz system clock; all cycle counts are derived from it here.
package rvc_pkg;

   // ****************************************************
   // Serial target addressing
   // ****************************************************
   localparam logic [6:0] OWN_ADDR = 7'h42;
   localparam logic [4:0] HS_CODE = 5'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ****************************************************
   // Register indices, resets and field positions
   // ****************************************************
   localparam logic [2:0] IDX_V1 = 3'h1;
   localparam logic [2:0] IDX_V2 = 3'h2;
   localparam logic [2:0] IDX_CTRL = 3'h3;
   localparam logic [2:0] IDX_STAT = 3'h5;
   localparam logic [7:0] V_RST = 8'h64;
   localparam logic [7:0] CTRL_RST = 8'h6f;
   localparam int CTRL_RESET = 7;
   localparam int CTRL_FORCED_PWM_OPERATION_CHG = 6;
   localparam int CTRL_SWEN = 5;
   localparam int CTRL_FORCED_PWM_OPERATION = 4;
   localparam int CTRL_DISCH = 3;
   localparam int CTRL_HICCUP = 2;
   localparam int STAT_THERM = 4;
   localparam int STAT_HICCUP = 3;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_MHZ = 50;
   localparam int STEP0_NS = 250;
   localparam int STEP1_NS = 500;
   localparam int STEP2_NS = 1000;
   localparam int STEP3_NS = 5000;
   localparam logic [8:0] STEP0_CYC = 9'((STEP0_NS * CLK_MHZ) / 1000);
   localparam logic [8:0] STEP1_CYC = 9'((STEP1_NS * CLK_MHZ) / 1000);
   localparam logic [8:0] STEP2_CYC = 9'((STEP2_NS * CLK_MHZ) / 1000);
   localparam logic [8:0] STEP3_CYC = 9'((STEP3_NS * CLK_MHZ) / 1000);
   localparam int PG_DEGLITCH_NS = 16000;
   localparam logic [9:0] PG_DEGLITCH_CYC = 10'((PG_DEGLITCH_NS * CLK_MHZ) / 1000);

   typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
      ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD} rvc_state_t;

endpackage

// *** design/rvc_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to sys_clk; output moves when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rvc_sync
#(
   parameter int WIDTH = 4
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   logic [WIDTH-1:0] out_d;

   // Take a bit only when the last two stages agree
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   // Stage registers; buses idle high
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         out_q <= '1;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule
`default_nettype wire

// *** testbench/rvc_i2c_ctrl.sv ***
// Behavioural serial-bus controller that drives SCL and pulls SDA for the target bench.
// Assumes the bench resolves SDA from all pull-downs with a pull-up; SCL idles high.
`timescale 1ns/1ps
`default_nettype none
module rvc_i2c_ctrl
#(
   parameter int LOW_NS = 150,
   parameter int HIGH_NS = 100
)
(
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // ****************************************************
   // Bus conditions
   // ****************************************************
   // Idle bus: SCL driven high, SDA released to the pull-up
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Start and repeated start: SDA falls while SCL is high
   task automatic start();
      #50 sda_pull = 1'b0;
      #50 scl = 1'b1;
      #HIGH_NS sda_pull = 1'b1;
      #HIGH_NS scl = 1'b0;
   endtask

   // Stop: SDA rises while SCL is high, then the bus rests idle
   task automatic stop();
      #50 sda_pull = 1'b1;
      #(LOW_NS - 50) scl = 1'b1;
      #HIGH_NS sda_pull = 1'b0;
      #(3 * HIGH_NS);
   endtask

   // ****************************************************
   // Bits and bytes
   // ****************************************************
   // Data changes only in the low phase and stays through the high phase
   task automatic bit_out(input logic b);
      #50 sda_pull = ~b;
      #(LOW_NS - 50) scl = 1'b1;
      #HIGH_NS scl = 1'b0;
   endtask

   // Line released, sampled in the middle of the high phase
   task automatic bit_in(output logic b);
      #50 sda_pull = 1'b0;
      #(LOW_NS - 50) scl = 1'b1;
      #(HIGH_NS / 2) b = sda;
      #(HIGH_NS / 2) scl = 1'b0;
   endtask

   // Eight bits MSB first, then the receiver's acknowledge slot
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   endtask

   // Controller receives a byte and answers acknowledge or not
   task automatic recv(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--)
         bit_in(d[i]);
      bit_out(~ack);
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench of the regulator serial-control core.
// Assumes the controller model in rvc_i2c_ctrl.sv and a pulled-up open-drain SDA.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic setpoint_select_pin = 1'b1;
   logic startup_done = 1'b0;
   logic vout_in_window = 1'b0;
   logic thermal_warning = 1'b1;
   logic hiccup_seen = 1'b1;
   logic scl, c_pull, sda_w, sda_oe, power_good_oe, forced_pwm_operation, hs_mode;
   logic [7:0] setpoint_code;
   logic [1:0] ramp_speed;
   logic [3:0] ctl_bits;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;

   // ****************************************************
   // Clock, wire resolution and instances
   // ****************************************************
   always #10 sys_clk = ~sys_clk;
   assign sda_w = ~(c_pull | sda_oe);

   rvc_i2c_ctrl u_ctrl (.scl(scl), .sda_pull(c_pull), .sda(sda_w));

   rvc_core u_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
      .setpoint_select_pin(setpoint_select_pin), .startup_done(startup_done), .vout_in_window(vout_in_window),
      .thermal_warning(thermal_warning), .hiccup_seen(hiccup_seen), .power_good_output(),
      .power_good_oe(power_good_oe), .setpoint_code(setpoint_code), .forced_pwm_operation(forced_pwm_operation),
      .light_load_pwm(ctl_bits[3]), .sw_enable(ctl_bits[2]), .discharge_enable(ctl_bits[1]),
      .hiccup_enable(ctl_bits[0]), .ramp_speed(ramp_speed),
      .hs_mode(hs_mode));

   // ****************************************************
   // Checking and closing
   // ****************************************************
   task automatic give_verdict();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Hang guard well above the expected run length
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_total++;
         give_verdict();
      end
   end

   // ****************************************************
   // Register access over the serial bus
   // ****************************************************
   // Optional high-speed entry: code unanswered, then repeated start
   task automatic open_x(input logic hs);
      logic a;
      u_ctrl.start();
      if (hs)
      begin
         u_ctrl.send(8'h08, a);
         chk(8'(a), 8'h00);
         chk(8'(hs_mode), 8'h01);
         u_ctrl.start();
      end
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] dat);
      logic a1, a2, a3;
      open_x(1'b0);
      u_ctrl.send(8'h84, a1);
      u_ctrl.send(idx, a2);
      u_ctrl.send(dat, a3);
      u_ctrl.stop();
      chk(8'({a1, a2, a3}), 8'h07);
   endtask

   task automatic reg_rd(input logic hs, input logic [7:0] idx, output logic [7:0] d);
      logic a1, a2, a3;
      open_x(hs);
      u_ctrl.send(8'h84, a1);
      u_ctrl.send(idx, a2);
      u_ctrl.start();
      u_ctrl.send(8'h85, a3);
      u_ctrl.recv(d, 1'b0);
      u_ctrl.stop();
      chk(8'({a1, a2, a3}), 8'h07);
   endtask

   // Waits for the setpoint to move, counting cycles at the falling edge
   task automatic wait_chg(output int n);
      logic [7:0] old;
      old = setpoint_code;
      n = 0;
      while (setpoint_code === old && n < 4000)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask

   // ****************************************************
   // Test sequence
   // ****************************************************
   initial
   begin
      logic [7:0] d;
      logic [7:0] tgt;
      logic a;
      int n;
      logic [7:0] rd_exp [8] = '{8'h00, 8'h64, 8'h64, 8'h6f, 8'h00, 8'h18, 8'h00, 8'h00};
      int per [4] = '{int'(rvc_pkg::STEP0_CYC), int'(rvc_pkg::STEP1_CYC), int'(rvc_pkg::STEP2_CYC),
         int'(rvc_pkg::STEP3_CYC)};
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(setpoint_code, 8'h64);
      chk(8'(ramp_speed), 8'h03);
      chk(8'(power_good_oe), 8'h01);
      chk(8'(ctl_bits), 8'h07);
      u_ctrl.stop();
      $display("test reset done");
      // Every index read back, unlisted ones as zero
      for (int i = 0; i < 8; i++)
      begin
         reg_rd(1'b0, 8'(i), d);
         chk(d, rd_exp[i]);
      end
      // Foreign address is left unanswered, next access still works
      u_ctrl.start();
      u_ctrl.send(8'h86, a);
      u_ctrl.stop();
      chk(8'(a), 8'h00);
      $display("test reads done");
      reg_wr(8'h02, 8'h70);
      reg_wr(8'h09, 8'h11);
      reg_wr(8'h04, 8'h22);
      reg_rd(1'b1, 8'h02, d);
      chk(d, 8'h70);
      chk(8'(hs_mode), 8'h00);
      reg_rd(1'b0, 8'h01, d);
      chk(d, 8'h64);
      reg_rd(1'b0, 8'h04, d);
      chk(d, 8'h00);
      // Index with upper bits set reads as zero
      reg_rd(1'b0, 8'h09, d);
      chk(d, 8'h00);
      $display("test writes done");
      // Each ramp speed: select flips, step spacing measured
      for (int sp = 0; sp < 4; sp++)
      begin
         reg_wr(8'h6c | 8'(sp), 8'h00);
         reg_wr(8'h03, 8'h6c | 8'(sp));
         chk(8'(ramp_speed), 8'(sp));
         if (sp == 0)
            chk(setpoint_code, 8'h64);
         @(posedge sys_clk);
         startup_done <= 1'b1;
         setpoint_select_pin <= (sp % 2 == 0);
         tgt = (sp % 2 == 0) ? 8'h70 : 8'h64;
         wait_chg(n);
         chk(8'(forced_pwm_operation), 8'h01);
         wait_chg(n);
         chk(8'(n >= per[sp] && n <= per[sp] + 1), 8'h01);
         n = 0;
         while (setpoint_code !== tgt && n < 4000)
         begin
            @(negedge sys_clk);
            n++;
         end
         chk(setpoint_code, tgt);
         repeat (2) @(negedge sys_clk);
         chk(8'(forced_pwm_operation), 8'h00);
      end
      $display("test ramp done");
      // Power good with deglitch, a short dip must not show
      @(posedge sys_clk);
      vout_in_window <= 1'b1;
      repeat (700) @(negedge sys_clk);
      chk(8'(power_good_oe), 8'h01);
      repeat (150) @(negedge sys_clk);
      chk(8'(power_good_oe), 8'h00);
      @(posedge sys_clk);
      vout_in_window <= 1'b0;
      repeat (100) @(posedge sys_clk);
      vout_in_window <= 1'b1;
      repeat (900) @(negedge sys_clk);
      chk(8'(power_good_oe), 8'h00);
      @(posedge sys_clk);
      vout_in_window <= 1'b0;
      repeat (900) @(negedge sys_clk);
      chk(8'(power_good_oe), 8'h01);
      $display("test power good done");
      // Reset bit restores the setpoint registers
      reg_wr(8'h03, 8'h80);
      reg_rd(1'b0, 8'h02, d);
      chk(d, 8'h64);
      chk(8'(ramp_speed), 8'h03);
      chk(8'(ctl_bits), 8'h07);
      $display("test soft reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
